//--- hdl/itf_core.sv
// Instruction cycle sequencer with accumulator, status flags and watchdog flags
//
// Behaviour
// RULE_01 - Add and subtract forms update zero, carry, half carry and signed wrap.
// RULE_02 - Decimal adjust writes the adjusted accumulator to memory, changing only carry.
// RULE_03 - Logic and complement forms take one cycle and change only zero.
// RULE_04 - Increment and decrement change only zero; accumulator forms keep memory intact.
// RULE_05 - Plain rotates keep flags; through-carry rotates shift carry in, change carry.
// RULE_06 - Moves and immediate loads take one cycle and change no flag.
// RULE_07 - Bit clear and set change only the indexed bit 0 to 7, no flag.
// RULE_08 - Jump, call, returns and interrupt return take two cycles, no flag.
// RULE_09 - Zero, bit and increment or decrement skips exist, none touch flags.
// RULE_10 - A taken skip costs two cycles, an untaken one costs one.
// RULE_11 - Writing the program counter low byte costs two cycles.
// RULE_12 - Table fetches take two cycles; high part to table register, low to memory.
// RULE_13 - Nibble exchange swaps halves into memory or accumulator, no flag.
// RULE_14 - Pre-clear pair clears expiry and power-down flags only when back to back.
// RULE_15 - Power-down entry takes one cycle and updates expiry and power-down flags.
// RULE_16 - One instruction cycle is four system clocks.
// RULE_17 - Single watchdog clear resets the watchdog and clears both flags.
// RULE_18 - Power-down stops execution and clock, clears watchdog, sets power-down flag.
// RULE_19 - Decimal adjust adds six per nibble above nine or with its carry set.
// RULE_20 - Memory write-back lands inside the instruction's own cycle count.
`timescale 1ns/1ps
`default_nettype none
`include "itf_map.svh"
module itf_core import itf_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ce_in,
  input  wire logic        instr_valid_in,
  input  wire itf_op_t     instr_op_in,
  input  wire logic        src_imm_in,
  input  wire logic        dst_mem_in,
  input  wire logic        dst_pc_low_in,
  input  wire logic [7:0]  mem_addr_in,
  input  wire logic [7:0]  mem_data_in,
  input  wire logic [7:0]  imm_in,
  input  wire logic [2:0]  bit_sel_in,
  input  wire logic [15:0] tbl_data_in,
  input  wire logic        wdt_timeout_in,
  input  wire logic        wake_in,
  output logic             instr_ready_out,
  output logic [7:0]       acc_out,
  output logic             zero_flag_out,
  output logic             carry_flag_out,
  output logic             half_carry_flag_out,
  output logic             signed_wrap_flag_out,
  output logic             watchdog_expiry_flag_out,
  output logic             powerdown_flag_out,
  output logic [7:0]       table_high_byte_reg_out,
  output logic             mem_we_out,
  output logic [7:0]       mem_waddr_out,
  output logic [7:0]       mem_wdata_out,
  output logic             skip_out,
  output logic             second_cycle_out,
  output logic             tbl_req_out,
  output itf_page_t        tbl_page_out,
  output logic             wdt_clear_out,
  output logic             clk_stop_out
);

  itf_state_t st_q;
  itf_state_t st_d;
  itf_page_t  page_q;
  itf_wd_t    wd_prev_q;
  logic [1:0] ph_q;
  logic [7:0] acc_q;
  logic [7:0] tbh_q;
  logic [7:0] wdata_q;
  logic [7:0] waddr_q;
  logic       cf_q;
  logic       hcf_q;
  logic       swf_q;
  logic       zf_q;
  logic       expf_q;
  logic       pdn_q;
  logic       we_q;
  logic       skip_q;
  logic       wdc_q;
  logic       treq_q;

  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_hc;
  logic       alu_sw;
  logic       alu_z;
  logic       upd_z;
  logic       upd_c;
  logic       upd_ar;
  logic       alu_skip;

  // Decode of the presented instruction
  wire itf_op_t op       = instr_op_in;
  wire          cyc_end  = (ph_q == `ITF_PHASE_LAST);
  wire          is_tbl   = (op == OP_TBL_PAGE) || (op == OP_TBL_CUR) || (op == OP_TBL_LAST);
  wire          is_br    = (op == OP_BRANCH) || (op == OP_CALL) || (op == OP_EXIT) ||
                           (op == OP_EXIT_LIT) || (op == OP_INT_EXIT);
  wire          mem_only = (op == OP_BCD_ADJ) || (op == OP_STORE_ACC) ||
                           (op == OP_BIT_CLR) || (op == OP_BIT_SET) ||
                           (op == OP_BYTE_CLR) || (op == OP_BYTE_SET);
  wire          acc_only = (op == OP_LOAD_ACC) || (op == OP_EXIT_LIT) ||
                           (op == OP_SKIP_Z_COPY);
  wire          dst_sel  = (op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR,
                           OP_XOR, OP_CMPL, OP_INC, OP_DEC, OP_ROT_R, OP_ROT_RC,
                           OP_ROT_L, OP_ROT_LC, OP_INC_SKIP, OP_DEC_SKIP, OP_SWAP});
  wire          wr_mem   = mem_only || (dst_sel && dst_mem_in);
  wire          wr_acc   = acc_only || (dst_sel && !dst_mem_in);
  wire          pcx_wr   = wr_mem && dst_pc_low_in;
  wire          long_op  = is_br || is_tbl || alu_skip || pcx_wr; // RULE_08 RULE_10 RULE_11 RULE_12
  wire [7:0]    opnd     = (src_imm_in || op == OP_EXIT_LIT) ? imm_in : mem_data_in;
  wire          is_halt  = (op == OP_HALT);
  wire          fire     = instr_ready_out && instr_valid_in && ce_in;
  wire          tbl_done = (st_q == ST_EXTRA) && cyc_end && treq_q && ce_in;
  // Pre-clear counts only when the other half ran as the previous instruction
  wire          wd_pair  = ((op == OP_WDT_PRE1) && (wd_prev_q == WD_SECOND)) ||
                           ((op == OP_WDT_PRE2) && (wd_prev_q == WD_FIRST)); // RULE_14
  wire          wd_hit   = fire && ((op == OP_WDT_CLR) || wd_pair); // RULE_17
  wire          halt_go  = fire && is_halt;

  assign instr_ready_out          = (st_q == ST_RUN) && cyc_end; // RULE_16
  assign acc_out                  = acc_q;
  assign zero_flag_out            = zf_q;
  assign carry_flag_out           = cf_q;
  assign half_carry_flag_out      = hcf_q;
  assign signed_wrap_flag_out     = swf_q;
  assign watchdog_expiry_flag_out = expf_q;
  assign powerdown_flag_out       = pdn_q;
  assign table_high_byte_reg_out  = tbh_q;
  assign mem_we_out               = we_q;
  assign mem_waddr_out            = waddr_q;
  assign mem_wdata_out            = wdata_q;
  assign skip_out                 = skip_q;
  assign second_cycle_out         = (st_q == ST_EXTRA);
  assign tbl_req_out              = treq_q;
  assign tbl_page_out             = page_q;
  assign wdt_clear_out            = wdc_q;
  assign clk_stop_out             = (st_q == ST_HALT); // RULE_18

  itf_alu i_itf_alu (
    .op_in         (op),
    .acc_in        (acc_q),
    .opnd_in       (opnd),
    .bit_in        (bit_sel_in),
    .c_in          (cf_q),
    .ac_in         (hcf_q),
    .res_out       (alu_res),
    .c_out         (alu_c),
    .ac_out        (alu_hc),
    .ov_out        (alu_sw),
    .z_out         (alu_z),
    .upd_zf_out    (upd_z),
    .upd_cf_out    (upd_c),
    .upd_arith_out (upd_ar),
    .skip_out      (alu_skip)
  );

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_RUN: begin
        if (halt_go) begin
          st_d = ST_HALT; // RULE_15
        end else if (fire && long_op) begin
          st_d = ST_EXTRA;
        end
      end
      ST_EXTRA: begin
        if (cyc_end) begin
          st_d = ST_RUN;
        end
      end
      ST_HALT: begin
        if (wake_in) begin
          st_d = ST_RUN;
        end
      end
      default: st_d = ST_RUN;
    endcase
  end

  // Phase held at zero while halted so a wake starts a clean cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= ST_RUN;
      ph_q <= `ITF_PHASE_RST;
    end else if (ce_in) begin
      st_q <= st_d;
      ph_q <= (st_q == ST_HALT) ? `ITF_PHASE_RST : ph_q + `ITF_PHASE_STEP; // RULE_16
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      acc_q <= `ITF_BYTE_RST;
    end else if (fire && wr_acc) begin
      acc_q <= alu_res; // RULE_04 RULE_06 RULE_13
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      zf_q  <= `ITF_FLAG_RST;
      cf_q  <= `ITF_FLAG_RST;
      hcf_q <= `ITF_FLAG_RST;
      swf_q <= `ITF_FLAG_RST;
    end else if (fire) begin
      zf_q  <= upd_z ? alu_z : zf_q; // RULE_01 RULE_03 RULE_04
      cf_q  <= upd_c ? alu_c : cf_q; // RULE_02 RULE_05
      hcf_q <= upd_ar ? alu_hc : hcf_q; // RULE_01
      swf_q <= upd_ar ? alu_sw : swf_q; // RULE_01
    end
  end

  // A timeout in the same clock as a clear still sets the expiry flag
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      expf_q <= `ITF_FLAG_RST;
      pdn_q  <= `ITF_FLAG_RST;
    end else if (ce_in) begin
      if (halt_go) begin
        expf_q <= 1'b0; // RULE_18
        pdn_q  <= 1'b1; // RULE_15
      end else if (wd_hit) begin
        expf_q <= 1'b0; // RULE_14 RULE_17
        pdn_q  <= 1'b0;
      end
      if (wdt_timeout_in) begin
        expf_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wd_prev_q <= WD_NONE;
      wdc_q     <= 1'b0;
    end else if (ce_in) begin
      wdc_q <= wd_hit || halt_go; // RULE_17 RULE_18
      if (fire) begin
        wd_prev_q <= (op == OP_WDT_PRE1) ? WD_FIRST :
                     (op == OP_WDT_PRE2) ? WD_SECOND : WD_NONE; // RULE_14
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      we_q    <= 1'b0;
      skip_q  <= 1'b0;
      wdata_q <= `ITF_BYTE_RST;
      waddr_q <= `ITF_BYTE_RST;
    end else if (ce_in) begin
      we_q   <= (fire && wr_mem) || tbl_done; // RULE_20
      skip_q <= fire && alu_skip; // RULE_10
      if (fire) begin
        wdata_q <= alu_res; // RULE_07
        waddr_q <= mem_addr_in;
      end else if (tbl_done) begin
        wdata_q <= tbl_data_in[`ITF_TBL_LO_MSB:`ITF_TBL_LO_LSB]; // RULE_12
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      treq_q <= 1'b0;
      tbh_q  <= `ITF_BYTE_RST;
      page_q <= PG_GIVEN;
    end else if (fire && is_tbl) begin
      treq_q <= 1'b1; // RULE_12
      page_q <= (op == OP_TBL_PAGE) ? PG_GIVEN : (op == OP_TBL_CUR) ? PG_CUR : PG_LAST;
    end else if (tbl_done) begin
      treq_q <= 1'b0;
      tbh_q  <= tbl_data_in[`ITF_TBL_HI_MSB:`ITF_TBL_HI_LSB]; // RULE_12
    end
  end

  // Timing checks assume the clock enable stays high across the window
  a_cycle_spacing: assert property (@(posedge clk_in) disable iff (sys_rst_in || !ce_in) // RULE_16
    fire |=> (!instr_ready_out) [*3]) else $error("instruction accepted inside one cycle");

  a_branch_two_cyc: assert property (@(posedge clk_in) disable iff (sys_rst_in || !ce_in) // RULE_08
    fire && is_br |=> (!instr_ready_out) [*7] ##1 instr_ready_out)
    else $error("branch did not take two cycles");

  a_skip_cycles: assert property (@(posedge clk_in) disable iff (sys_rst_in || !ce_in) // RULE_10
    fire && !is_halt |=> (second_cycle_out == $past(long_op)) && (skip_out == $past(alu_skip)))
    else $error("skip cycle count wrong");

  a_pc_low_long: assert property (@(posedge clk_in) disable iff (sys_rst_in || !ce_in) // RULE_11
    fire && pcx_wr |=> second_cycle_out [*4]) else $error("pc low write not two cycles");

  a_add_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in || !ce_in) // RULE_01
    fire && (op == OP_ADD) |=> zero_flag_out == ($past(alu_res) == `ITF_BYTE_RST) &&
    carry_flag_out == $past(alu_c) && signed_wrap_flag_out == $past(alu_sw))
    else $error("add flags not updated");

  a_logic_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in || !ce_in) // RULE_03
    fire && (op inside {OP_AND, OP_OR, OP_XOR, OP_CMPL}) && !pcx_wr |=>
    $stable(carry_flag_out) && $stable(half_carry_flag_out) &&
    !second_cycle_out) else $error("logic op touched carry or ran long");

  a_rotate_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in || !ce_in) // RULE_05
    fire && (op == OP_ROT_L) |=> $stable(carry_flag_out) && $stable(zero_flag_out))
    else $error("plain rotate changed flags");

  a_adjust_write: assert property (@(posedge clk_in) disable iff (sys_rst_in || !ce_in) // RULE_02
    fire && (op == OP_BCD_ADJ) |=> mem_we_out && $stable(zero_flag_out) && $stable(acc_out))
    else $error("decimal adjust result misplaced");

  a_table_write: assert property (@(posedge clk_in) disable iff (sys_rst_in || !ce_in) // RULE_12
    fire && is_tbl |=> tbl_req_out [*4] ##1 (mem_we_out && !tbl_req_out))
    else $error("table low byte not written at second cycle end");

  a_preclear_single: assert property (@(posedge clk_in) disable iff (sys_rst_in || !ce_in) // RULE_14
    fire && (op == OP_WDT_PRE1) && (wd_prev_q != WD_SECOND) |=> !wdt_clear_out)
    else $error("lone pre-clear cleared watchdog");

  a_halt_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in || !ce_in) // RULE_15
    halt_go |=> powerdown_flag_out && clk_stop_out && wdt_clear_out)
    else $error("power-down entry flags wrong");

endmodule // itf_core
`default_nettype wire

//--- hdl/itf_map.svh
// Offsets, field positions, reset values and timing counts of the instruction timing block
`ifndef ITF_MAP_SVH
`define ITF_MAP_SVH

`define ITF_CLK_NS      20
`define ITF_ICYC_CLKS   4
`define ITF_PHASE_LAST  2'(`ITF_ICYC_CLKS - 1)
`define ITF_PHASE_RST   2'h0
`define ITF_PHASE_STEP  2'h1

`define ITF_BYTE_RST    8'h00
`define ITF_BYTE_ONES   8'hFF
`define ITF_FLAG_RST    1'b0
`define ITF_ONE         8'h01
`define ITF_MINUS_ONE   8'hFF

`define ITF_NIB_MAX     4'h9
`define ITF_ADJ_LO      8'h06
`define ITF_ADJ_HI      8'h60

`define ITF_TBL_HI_MSB  15
`define ITF_TBL_HI_LSB  8
`define ITF_TBL_LO_MSB  7
`define ITF_TBL_LO_LSB  0

`endif

//--- hdl/itf_pkg.sv
// Types of the instruction timing block
package itf_pkg;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_BCD_ADJ,
    OP_AND, OP_OR, OP_XOR, OP_CMPL, OP_INC, OP_DEC,
    OP_ROT_R, OP_ROT_RC, OP_ROT_L, OP_ROT_LC,
    OP_LOAD_ACC, OP_STORE_ACC, OP_BIT_CLR, OP_BIT_SET,
    OP_BYTE_CLR, OP_BYTE_SET, OP_SWAP,
    OP_BRANCH, OP_CALL, OP_EXIT, OP_EXIT_LIT, OP_INT_EXIT,
    OP_SKIP_Z, OP_SKIP_Z_COPY, OP_SKIP_BIT_CLR, OP_SKIP_BIT_SET,
    OP_INC_SKIP, OP_DEC_SKIP,
    OP_TBL_PAGE, OP_TBL_CUR, OP_TBL_LAST,
    OP_WDT_CLR, OP_WDT_PRE1, OP_WDT_PRE2, OP_HALT
  } itf_op_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_EXTRA = 3'b010,
    ST_HALT  = 3'b100
  } itf_state_t;

  typedef enum logic [1:0] {PG_GIVEN, PG_CUR, PG_LAST} itf_page_t;

  typedef enum logic [1:0] {WD_NONE, WD_FIRST, WD_SECOND} itf_wd_t;

endpackage

//--- hdl/itf_alu.sv
// Result, flag and skip computation for one instruction
`timescale 1ns/1ps
`default_nettype none
`include "itf_map.svh"
module itf_alu import itf_pkg::*; (
  input  wire itf_op_t    op_in,
  input  wire logic [7:0] acc_in,
  input  wire logic [7:0] opnd_in,
  input  wire logic [2:0] bit_in,
  input  wire logic       c_in,
  input  wire logic       ac_in,
  output logic [7:0]      res_out,
  output logic            c_out,
  output logic            ac_out,
  output logic            ov_out,
  output logic            z_out,
  output logic            upd_zf_out,
  output logic            upd_cf_out,
  output logic            upd_arith_out,
  output logic            skip_out
);

  // Returns {wrap, half carry, carry, sum}
  function automatic logic [10:0] add_f(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    add_f = {(a[7] == b[7]) && (s[7] != a[7]), h[4], s};
  endfunction

  // Carry set means no borrow on subtract
  wire        is_sub = (op_in == OP_SUB) || (op_in == OP_SBC);
  wire        ar_cin = (op_in == OP_ADC || op_in == OP_SBC) ? c_in : is_sub;
  wire [10:0] ar     = add_f(acc_in, is_sub ? ~opnd_in : opnd_in, ar_cin);
  wire        id_dec = (op_in == OP_DEC) || (op_in == OP_DEC_SKIP);
  wire [10:0] id     = add_f(opnd_in, id_dec ? `ITF_MINUS_ONE : `ITF_ONE, 1'b0);
  wire        adj_lo = (acc_in[3:0] > `ITF_NIB_MAX) || ac_in;
  wire        adj_hi = (acc_in[7:4] > `ITF_NIB_MAX) || c_in;
  wire [7:0]  adj    = (adj_hi ? `ITF_ADJ_HI : `ITF_BYTE_RST) |
                       (adj_lo ? `ITF_ADJ_LO : `ITF_BYTE_RST);
  wire [10:0] dr     = add_f(acc_in, adj, 1'b0);
  wire [7:0]  bm     = `ITF_ONE << bit_in;
  wire [7:0]  lg     = (op_in == OP_AND) ? (acc_in & opnd_in) :
                       (op_in == OP_OR)  ? (acc_in | opnd_in) :
                       (op_in == OP_XOR) ? (acc_in ^ opnd_in) : ~opnd_in;

  assign z_out = (res_out == `ITF_BYTE_RST);

  always_comb begin
    res_out       = acc_in;
    c_out         = c_in;
    ac_out        = ac_in;
    ov_out        = 1'b0;
    upd_zf_out    = 1'b0;
    upd_cf_out    = 1'b0;
    upd_arith_out = 1'b0;
    skip_out      = 1'b0;
    case (op_in)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        res_out       = ar[7:0]; // RULE_01
        c_out         = ar[8];
        ac_out        = ar[9];
        ov_out        = ar[10];
        upd_zf_out    = 1'b1;
        upd_cf_out    = 1'b1;
        upd_arith_out = 1'b1;
      end
      OP_BCD_ADJ: begin
        res_out    = dr[7:0]; // RULE_19
        c_out      = c_in | dr[8]; // RULE_02
        upd_cf_out = 1'b1;
      end
      OP_AND, OP_OR, OP_XOR, OP_CMPL: begin
        res_out    = lg; // RULE_03
        upd_zf_out = 1'b1;
      end
      OP_INC, OP_DEC: begin
        res_out    = id[7:0]; // RULE_04
        upd_zf_out = 1'b1;
      end
      OP_ROT_R: res_out = {opnd_in[0], opnd_in[7:1]}; // RULE_05
      OP_ROT_L: res_out = {opnd_in[6:0], opnd_in[7]}; // RULE_05
      OP_ROT_RC: begin
        res_out    = {c_in, opnd_in[7:1]}; // RULE_05
        c_out      = opnd_in[0];
        upd_cf_out = 1'b1;
      end
      OP_ROT_LC: begin
        res_out    = {opnd_in[6:0], c_in}; // RULE_05
        c_out      = opnd_in[7];
        upd_cf_out = 1'b1;
      end
      OP_LOAD_ACC, OP_EXIT_LIT: res_out = opnd_in; // RULE_06
      OP_STORE_ACC: res_out = acc_in; // RULE_06
      OP_BIT_CLR: res_out = opnd_in & ~bm; // RULE_07
      OP_BIT_SET: res_out = opnd_in | bm; // RULE_07
      OP_BYTE_CLR: res_out = `ITF_BYTE_RST;
      OP_BYTE_SET: res_out = `ITF_BYTE_ONES;
      OP_SWAP: res_out = {opnd_in[3:0], opnd_in[7:4]}; // RULE_13
      OP_SKIP_Z: skip_out = (opnd_in == `ITF_BYTE_RST); // RULE_09
      OP_SKIP_Z_COPY: begin
        res_out  = opnd_in; // RULE_09
        skip_out = (opnd_in == `ITF_BYTE_RST);
      end
      OP_SKIP_BIT_CLR: skip_out = !opnd_in[bit_in]; // RULE_09
      OP_SKIP_BIT_SET: skip_out = opnd_in[bit_in]; // RULE_09
      OP_INC_SKIP, OP_DEC_SKIP: begin
        res_out  = id[7:0]; // RULE_09
        skip_out = (id[7:0] == `ITF_BYTE_RST);
      end
      default: ;
    endcase
  end

endmodule // itf_alu
`default_nettype wire

//--- sim/test_itf_core.sv
// Self-checking bench of the instruction timing core
`timescale 1ns/1ps
`default_nettype none
module test_itf_core;
  import itf_pkg::*;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1, instr_valid_in = 1'b0;
  itf_op_t     instr_op_in = OP_NOP;
  logic        src_imm_in = 1'b0, dst_mem_in = 1'b0, dst_pc_low_in = 1'b0;
  logic [7:0]  mem_addr_in = 8'h2A, mem_data_in = 8'h00, imm_in = 8'h00;
  logic [2:0]  bit_sel_in = 3'h0;
  logic [15:0] tbl_data_in = 16'h0000;
  logic        wdt_timeout_in = 1'b0, wake_in = 1'b0;
  logic        instr_ready_out, zero_flag_out, carry_flag_out, half_carry_flag_out;
  logic        signed_wrap_flag_out, watchdog_expiry_flag_out, powerdown_flag_out;
  logic        mem_we_out, skip_out, second_cycle_out, tbl_req_out, wdt_clear_out;
  logic        clk_stop_out;
  logic [7:0]  acc_out, table_high_byte_reg_out, mem_waddr_out, mem_wdata_out;
  itf_page_t   tbl_page_out;
  wire  [3:0]  zcav = {zero_flag_out, carry_flag_out, half_carry_flag_out,
                       signed_wrap_flag_out};
  int          mismatches = 0, samples_checked = 0;

  itf_core i_itf_core (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .instr_valid_in(instr_valid_in), .instr_op_in(instr_op_in), .src_imm_in(src_imm_in),
    .dst_mem_in(dst_mem_in), .dst_pc_low_in(dst_pc_low_in), .mem_addr_in(mem_addr_in),
    .mem_data_in(mem_data_in), .imm_in(imm_in), .bit_sel_in(bit_sel_in),
    .tbl_data_in(tbl_data_in), .wdt_timeout_in(wdt_timeout_in), .wake_in(wake_in),
    .instr_ready_out(instr_ready_out), .acc_out(acc_out), .zero_flag_out(zero_flag_out),
    .carry_flag_out(carry_flag_out), .half_carry_flag_out(half_carry_flag_out),
    .signed_wrap_flag_out(signed_wrap_flag_out),
    .watchdog_expiry_flag_out(watchdog_expiry_flag_out),
    .powerdown_flag_out(powerdown_flag_out),
    .table_high_byte_reg_out(table_high_byte_reg_out), .mem_we_out(mem_we_out),
    .mem_waddr_out(mem_waddr_out), .mem_wdata_out(mem_wdata_out), .skip_out(skip_out),
    .second_cycle_out(second_cycle_out), .tbl_req_out(tbl_req_out),
    .tbl_page_out(tbl_page_out), .wdt_clear_out(wdt_clear_out), .clk_stop_out(clk_stop_out)
  );

  always #10 clk_in = ~clk_in;

  task automatic finish_test();
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for ready at a falling edge, offers one op, returns in its first answer cycle
  task automatic issue(input itf_op_t op, input logic is_imm, input logic to_mem,
                       input logic [7:0] mem, input logic [7:0] imm);
    int n;
    n = 0;
    while (instr_ready_out !== 1'b1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 40) mismatches++;
    instr_op_in = op;
    src_imm_in = is_imm;
    dst_mem_in = to_mem;
    mem_data_in = mem;
    imm_in = imm;
    instr_valid_in = 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    instr_valid_in = 1'b0;
  endtask

  // Cycle index at which ready returns, counted from the answer cycle
  task automatic icyc(input int start, input int exp);
    int n;
    n = start;
    while (instr_ready_out !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    chk(32'(n), 32'(exp));
  endtask

  task automatic t_arith();
    issue(OP_LOAD_ACC, 1'b1, 1'b0, 8'h00, 8'h7F);
    chk({acc_out, zcav}, 12'h7F0);
    icyc(1, 4);
    issue(OP_ADD, 1'b1, 1'b0, 8'h00, 8'h01);
    chk({acc_out, zcav}, 12'h803);
    icyc(1, 4);
    issue(OP_SUB, 1'b1, 1'b0, 8'h00, 8'h80);
    chk({acc_out, zcav}, 12'h00E);
    issue(OP_ADC, 1'b0, 1'b1, 8'h0F, 8'h00);
    chk({mem_we_out, mem_waddr_out, mem_wdata_out, acc_out, zcav}, 29'h12A10002);
    icyc(1, 4);
    issue(OP_SBC, 1'b0, 1'b0, 8'h00, 8'h00);
    chk({acc_out, zcav}, 12'hFF0);
  endtask

  task automatic t_bcd_logic();
    issue(OP_LOAD_ACC, 1'b1, 1'b0, 8'h00, 8'hAA);
    issue(OP_BCD_ADJ, 1'b0, 1'b1, 8'h00, 8'h00);
    chk({mem_we_out, mem_wdata_out, acc_out, zcav}, 21'h110AA4);
    issue(OP_AND, 1'b1, 1'b0, 8'h00, 8'h55);
    chk({acc_out, zcav}, 12'h00C);
    icyc(1, 4);
    issue(OP_CMPL, 1'b0, 1'b1, 8'h0F, 8'h00);
    chk({mem_we_out, mem_wdata_out, zcav}, 13'h1F04);
  endtask

  task automatic t_inc_rot();
    issue(OP_INC, 1'b0, 1'b0, 8'hFF, 8'h00);
    chk({mem_we_out, acc_out, zcav}, 13'h000C);
    issue(OP_DEC, 1'b0, 1'b1, 8'h01, 8'h00);
    chk({mem_we_out, mem_wdata_out, zcav}, 13'h100C);
    issue(OP_ROT_RC, 1'b0, 1'b0, 8'h02, 8'h00);
    chk({acc_out, zcav}, 12'h818);
    issue(OP_ROT_L, 1'b0, 1'b0, 8'h81, 8'h00);
    chk({acc_out, zcav}, 12'h038);
    issue(OP_ROT_LC, 1'b0, 1'b1, 8'h80, 8'h00);
    chk({mem_we_out, mem_wdata_out, zcav}, 13'h100C);
  endtask

  task automatic t_bits_move();
    bit_sel_in = 3'h7;
    issue(OP_BIT_SET, 1'b0, 1'b1, 8'h00, 8'h00);
    chk({mem_we_out, mem_wdata_out, zcav}, 13'h180C);
    bit_sel_in = 3'h0;
    issue(OP_BIT_CLR, 1'b0, 1'b1, 8'hFF, 8'h00);
    chk({mem_we_out, mem_wdata_out, zcav}, 13'h1FEC);
    issue(OP_STORE_ACC, 1'b0, 1'b1, 8'h00, 8'h00);
    chk({mem_we_out, mem_wdata_out}, 9'h103);
    icyc(1, 4);
    dst_pc_low_in = 1'b1;
    issue(OP_STORE_ACC, 1'b0, 1'b1, 8'h00, 8'h00);
    dst_pc_low_in = 1'b0;
    icyc(1, 8);
  endtask

  task automatic t_branch();
    itf_op_t ops [5] = '{OP_BRANCH, OP_CALL, OP_EXIT, OP_EXIT_LIT, OP_INT_EXIT};
    foreach (ops[k]) begin
      issue(ops[k], 1'b0, 1'b0, 8'h00, 8'h5A);
      chk({second_cycle_out, zcav}, 5'h1C);
      icyc(1, 8);
    end
    chk(acc_out, 8'h5A);
  endtask

  task automatic t_skip();
    itf_op_t    ops [7] = '{OP_SKIP_Z, OP_SKIP_Z, OP_SKIP_Z_COPY, OP_SKIP_BIT_CLR,
                            OP_SKIP_BIT_SET, OP_INC_SKIP, OP_DEC_SKIP};
    logic [7:0] mem [7] = '{8'h00, 8'h01, 8'h00, 8'h08, 8'h08, 8'hFF, 8'h05};
    logic       tak [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    bit_sel_in = 3'h3;
    foreach (ops[k]) begin
      issue(ops[k], 1'b0, 1'b0, mem[k], 8'h00);
      chk({skip_out, zcav}, {tak[k], 4'hC});
      icyc(1, tak[k] ? 8 : 4);
    end
    chk(acc_out, 8'h04);
  endtask

  task automatic t_table();
    itf_op_t ops [3] = '{OP_TBL_PAGE, OP_TBL_CUR, OP_TBL_LAST};
    foreach (ops[k]) begin
      tbl_data_in = 16'h1234 + 16'(k) * 16'h0101;
      issue(ops[k], 1'b0, 1'b1, 8'h00, 8'h00);
      chk({tbl_req_out, 2'(tbl_page_out)}, {1'b1, 2'(k)});
      repeat (4) @(negedge clk_in);
      chk({tbl_req_out, mem_we_out, table_high_byte_reg_out, mem_wdata_out},
          {2'b01, tbl_data_in});
      icyc(5, 8);
    end
  endtask

  task automatic t_swap();
    issue(OP_SWAP, 1'b0, 1'b0, 8'h3C, 8'h00);
    chk({mem_we_out, acc_out, zcav}, 13'h0C3C);
    issue(OP_SWAP, 1'b0, 1'b1, 8'hA5, 8'h00);
    chk({mem_we_out, mem_wdata_out, acc_out}, 17'h15AC3);
  endtask

  // Clock enable low must freeze the phase and hold the write pulse
  task automatic t_freeze();
    issue(OP_BYTE_SET, 1'b0, 1'b1, 8'h00, 8'h00);
    ce_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk({mem_we_out, mem_wdata_out, instr_ready_out}, 10'h3FE);
    ce_in = 1'b1;
    icyc(1, 4);
  endtask

  task automatic pulse_timeout();
    wdt_timeout_in = 1'b1;
    @(negedge clk_in);
    wdt_timeout_in = 1'b0;
  endtask

  task automatic t_watchdog();
    pulse_timeout();
    issue(OP_HALT, 1'b0, 1'b0, 8'h00, 8'h00);
    chk({powerdown_flag_out, watchdog_expiry_flag_out, wdt_clear_out, clk_stop_out},
        4'hB);
    repeat (6) @(negedge clk_in);
    chk({instr_ready_out, clk_stop_out, acc_out}, 10'h1C3);
    wake_in = 1'b1;
    @(negedge clk_in);
    wake_in = 1'b0;
    chk(clk_stop_out, 1'b0);
    icyc(1, 4);
    pulse_timeout();
    chk({watchdog_expiry_flag_out, powerdown_flag_out}, 2'b11);
    issue(OP_WDT_PRE1, 1'b0, 1'b0, 8'h00, 8'h00);
    issue(OP_WDT_PRE1, 1'b0, 1'b0, 8'h00, 8'h00);
    chk({watchdog_expiry_flag_out, powerdown_flag_out}, 2'b11);
    issue(OP_WDT_PRE2, 1'b0, 1'b0, 8'h00, 8'h00);
    chk({watchdog_expiry_flag_out, powerdown_flag_out}, 2'b00);
    pulse_timeout();
    issue(OP_WDT_CLR, 1'b0, 1'b0, 8'h00, 8'h00);
    chk({watchdog_expiry_flag_out, powerdown_flag_out, wdt_clear_out}, 3'b001);
  endtask

  // Whole run is a few hundred clocks; the limit leaves wide margin
  initial begin
    #100us;
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (5) @(negedge clk_in);
    sys_rst_in = 1'b0;
    chk({acc_out, zcav, watchdog_expiry_flag_out, powerdown_flag_out, mem_we_out,
         instr_ready_out}, 16'h0);
    t_arith();
    t_bcd_logic();
    t_inc_rot();
    t_bits_move();
    t_branch();
    t_skip();
    t_table();
    t_swap();
    t_freeze();
    t_watchdog();
    finish_test();
  end
endmodule // test_itf_core
`default_nettype wire
